// ---- design/camera_strobe_output_unit.v ----
// camera strobe output unit: APB registers, event select, pre-delay, two lines
//
// Behaviour
// - line one output only, line two bidirectional
// - line two drives strobe in strobe mode
// - inversion flips the driven line level
// - inversion is off after reset
// - enabled line pulses on selected event
// - exposure and acquisition start/stop sources
// - burst start and burst end sources
// - trigger-wait source shows waiting level
// - frame start and frame end sources
// - soft, hard, counter, timer trigger sources
// - zero duration lasts until the exposure end pulse
// - nonzero duration lasts programmed microseconds
// - delay after the selected event, 0..10000 us
// - pre-delay before exposure, 0..5000 us
//
// register map, byte offsets, line one then line two
//   0x00/0x10 config: source 3:0, invert 4, enable 5, drive 6
//   0x04/0x14 duration in us, zero lasts until exposure end
//   0x08/0x18 delay in us, saturates at its maximum
//   0x0c/0x1c pre-delay in us, saturates at its maximum
//   0x20 command, write only: bit 0 fires line one, bit 1 line two
//   0x24 status: line one, line two, synced pin, hold-off busy
//
// timing
//   event sampled at edge e moves the line at edge e+2
//   each microsecond of delay adds ten clock cycles
//   a nonzero duration holds the line ten cycles per microsecond
//   a zero duration holds it until the exposure end pulse
//   with pre-delay the strobe starts at the request and the
//   exposure waits the longest pre-delay of the enabled exposure-start lines
//   line two drives its pin only while drive is set
`timescale 1ns/1ns
`include "strobe_out_regs.vh"
module camera_strobe_output_unit #(
  parameter DUR_W = `DUR_W,                 // duration register width
  parameter DLY_W = `DLY_W                  // delay register width
) (
  input  wire        CLK_IN,                // system clock, 10 MHz
  input  wire        RST_N_IN,              // synchronous reset, low active
  input  wire        PSEL_IN,               // APB select
  input  wire        PENABLE_IN,            // APB access phase
  input  wire        PWRITE_IN,             // APB direction
  input  wire [7:0]  PADDR_IN,              // APB byte address
  input  wire [31:0] PWDATA_IN,             // APB write data
  output reg  [31:0] PRDATA_OUT,            // APB read data
  output reg         PREADY_OUT,            // APB ready
  output reg         PSLVERR_OUT,           // APB error, unmapped address
  input  wire        EXP_REQ_IN,            // exposure request from sequencer
  input  wire        EXP_END_IN,            // exposure end pulse
  input  wire        ACQ_START_IN,          // acquisition start pulse
  input  wire        ACQ_STOP_IN,           // acquisition stop pulse
  input  wire        BURST_START_IN,        // burst start pulse
  input  wire        BURST_END_IN,          // burst end pulse
  input  wire        TRIG_WAIT_IN,          // waiting for frame trigger, level
  input  wire        FRAME_START_IN,        // frame capture start pulse
  input  wire        FRAME_END_IN,          // frame capture end pulse
  input  wire        SOFT_TRIG_IN,          // software trigger pulse
  input  wire        HARD_TRIG_IN,          // hardware trigger pulse
  input  wire        CNT_TRIG_IN,           // counter trigger pulse
  output reg         EXP_START_OUT,         // exposure start, after hold-off
  output reg         LINE1_OUT,             // isolated output line
  output reg         LINE2_OUT,             // bidirectional line, out value
  output reg         LINE2_OE_N_OUT,        // line two enable, low drives
  input  wire        LINE2_IN               // bidirectional line, pin level
);
  localparam integer DIV_LAST_I = `US_CYCLES - 1;  // last cycle of a microsecond
  localparam [3:0]  DIV_LAST = DIV_LAST_I[3:0];    // divider end count
  localparam [31:0] DLY_MAX  = `DLY_MAX_US;
  localparam [31:0] PRE_MAX  = `PRE_MAX_US;

  reg [`CFG_W-1:0] cfg_q [0:1];             // per-line configuration
  reg [DUR_W-1:0]  dur_q [0:1];             // per-line duration, us
  reg [DLY_W-1:0]  dly_q [0:1];             // per-line delay, us
  reg [DLY_W-1:0]  pre_q [0:1];             // per-line pre-delay, us
  reg [1:0]        fire_q;                  // software fire, one cycle
  reg              in_meta_q;               // line two pin, first stage
  reg              in_sync_q;               // line two pin, second stage
  reg              hold_q;                  // exposure hold-off running
  reg [3:0]        hdiv_q;                  // hold-off cycle divider
  reg [DLY_W-1:0]  hcnt_q;                  // hold-off microseconds left
  wire [1:0]       act;                     // pulse generator levels

  // clamp a write to the documented range
  function [DLY_W-1:0] clamp;
    input [31:0] v;
    input [31:0] lim;
    begin
      // compare at full width so oversized writes saturate too
      clamp = (v > lim) ? lim[DLY_W-1:0] : v[DLY_W-1:0];
    end
  endfunction

  // register offset decode: whether the offset hits a mapped word
  function mapped;
    input [7:0] a;
    begin
      // line words fill 0x00 to 0x1c; command and status follow
      mapped = (a[7:5] == 3'b000 && a[1:0] == 2'b00) ||
               (a == `OFS_CMD) || (a == `OFS_STATUS);
    end
  endfunction

  // pre-delay that applies to a line: exposure-start source and enabled
  function [DLY_W-1:0] line_pre;
    input [`CFG_W-1:0] c;
    input [DLY_W-1:0]  p;
    begin
      // only enabled exposure-start lines hold the exposure off
      if (c[`CFG_EN_BIT] && c[`CFG_SRC_MSB:`CFG_SRC_LSB] == `SRC_EXP_START)
        line_pre = p;
      else
        line_pre = {DLY_W{1'b0}};
    end
  endfunction

  // longest pre-delay among the enabled exposure-start lines
  wire [DLY_W-1:0] pre0 = line_pre(cfg_q[0], pre_q[0]);
  wire [DLY_W-1:0] pre1 = line_pre(cfg_q[1], pre_q[1]);
  wire [DLY_W-1:0] pre_max = (pre0 > pre1) ? pre0 : pre1;

  // apb phases; a write lands in the access cycle
  wire setup  = PSEL_IN && !PENABLE_IN;
  wire access = PSEL_IN && PENABLE_IN && PREADY_OUT;
  wire wr     = access && PWRITE_IN && !PSLVERR_OUT;
  wire lsel   = PADDR_IN[4];                // line index of a line register
  wire lreg   = (PADDR_IN[7:5] == 3'b000);  // address hits a line register

  // APB answer: ready in the access phase, data registered at setup
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      // bus outputs quiet in reset
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
    end else begin
      // zero wait states: ready follows setup by one cycle
      PREADY_OUT  <= setup;
      PSLVERR_OUT <= setup && !mapped(PADDR_IN);
      // read data captured at setup, shown during access
      if (setup && !PWRITE_IN) begin
        // spare bits and write-only words read as zero
        PRDATA_OUT <= 32'h0000_0000;
        if (lreg) begin
          // word within the line block
          case ({4'h0, PADDR_IN[3:0]})
            `OFS_CFG: PRDATA_OUT[`CFG_W-1:0] <= cfg_q[lsel];
            `OFS_DUR: PRDATA_OUT[DUR_W-1:0]  <= dur_q[lsel];
            `OFS_DLY: PRDATA_OUT[DLY_W-1:0]  <= dly_q[lsel];
            `OFS_PRE: PRDATA_OUT[DLY_W-1:0]  <= pre_q[lsel];
            default:  PRDATA_OUT <= 32'h0000_0000;
          endcase
        end else if (PADDR_IN == `OFS_STATUS) begin
          // line levels, pin level, hold-off busy
          PRDATA_OUT[3:0] <= {hold_q, in_sync_q, LINE2_OUT, LINE1_OUT};
        end
      end
    end
  end

  // register writes; inversion and enable clear at reset
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      cfg_q[0] <= `CFG_RESET;
      cfg_q[1] <= `CFG_RESET;
      dur_q[0] <= {DUR_W{1'b0}};
      dur_q[1] <= {DUR_W{1'b0}};
      dly_q[0] <= {DLY_W{1'b0}};
      dly_q[1] <= {DLY_W{1'b0}};
      pre_q[0] <= {DLY_W{1'b0}};
      pre_q[1] <= {DLY_W{1'b0}};
      // no fire pending after reset
      fire_q   <= 2'b00;
    end else begin
      // fire bits are write-one pulses for the timer source
      fire_q <= (wr && PADDR_IN == `OFS_CMD) ? PWDATA_IN[1:0] : 2'b00;
      // refused writes never get here, wr excludes them
      if (wr && lreg) begin
        case ({4'h0, PADDR_IN[3:0]})
          `OFS_CFG: cfg_q[lsel] <= PWDATA_IN[`CFG_W-1:0];
          `OFS_DUR: dur_q[lsel] <= PWDATA_IN[DUR_W-1:0];
          // out-of-range delays saturate rather than wrap
          `OFS_DLY: dly_q[lsel] <= clamp(PWDATA_IN, DLY_MAX);
          `OFS_PRE: pre_q[lsel] <= clamp(PWDATA_IN, PRE_MAX);
          // unaligned offsets are refused before this point
          default:  dur_q[lsel] <= dur_q[lsel];
        endcase
      end
    end
  end

  // line two pin through two flops before use
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      // pin taken as low while in reset
      in_meta_q <= 1'b0;
      in_sync_q <= 1'b0;
    end else begin
      // only the second stage is read by logic
      in_meta_q <= LINE2_IN;
      in_sync_q <= in_meta_q;
    end
  end

  // exposure hold-off: request starts strobe, exposure waits pre-delay
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      // no exposure pending after reset
      hold_q        <= 1'b0;
      hdiv_q        <= 4'h0;
      hcnt_q        <= {DLY_W{1'b0}};
      EXP_START_OUT <= 1'b0;
    end else begin
      // exposure start is a one-cycle pulse
      EXP_START_OUT <= 1'b0;
      if (!hold_q) begin
        // requests during a hold-off are ignored
        if (EXP_REQ_IN) begin
          // no pre-delay on any enabled exposure-start line: start at once
          if (pre_max == {DLY_W{1'b0}}) begin
            EXP_START_OUT <= 1'b1;
          end else begin
            // divider restarts so the first microsecond is whole
            hold_q <= 1'b1;
            hdiv_q <= 4'h0;
            hcnt_q <= pre_max;
          end
        end
      end else begin
        // count microseconds, release exposure after the last
        hdiv_q <= (hdiv_q == DIV_LAST) ? 4'h0 : hdiv_q + 4'h1;
        if (hdiv_q == DIV_LAST) begin
          hcnt_q <= hcnt_q - {{(DLY_W-1){1'b0}}, 1'b1};
          if (hcnt_q == {{(DLY_W-1){1'b0}}, 1'b1}) begin
            hold_q        <= 1'b0;
            EXP_START_OUT <= 1'b1;
          end
        end
      end
    end
  end

  // internal events indexed by source code
  // code 12 is replaced per line by its fire bit
  // codes 13 to 15 select nothing
  wire [`SRC_COUNT-1:0] ev_base = {
    1'b0, CNT_TRIG_IN, HARD_TRIG_IN, SOFT_TRIG_IN,
    FRAME_END_IN, FRAME_START_IN, TRIG_WAIT_IN,
    BURST_END_IN, BURST_START_IN,
    ACQ_STOP_IN, ACQ_START_IN, EXP_END_IN, EXP_START_OUT
  };

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_line
      // source code and enable of this line
      wire [3:0] src = cfg_q[g][`CFG_SRC_MSB:`CFG_SRC_LSB];
      wire       en  = cfg_q[g][`CFG_EN_BIT];
      wire [`SRC_COUNT-1:0] ev = {fire_q[g], ev_base[`SRC_COUNT-2:0]};
      // with pre-delay the exposure-start pulse begins at the request
      wire pre_on = (src == `SRC_EXP_START) && (pre_q[g] != {DLY_W{1'b0}});
      // out-of-range source codes never fire
      wire sel_ev = (src < `SRC_COUNT) ? ev[src] : 1'b0;
      wire start  = en && (pre_on ? (EXP_REQ_IN && !hold_q) : sel_ev);
      wire lvl    = en && (src == `SRC_TRIG_WAIT);

      // delay and pulse timing of this line
      strobe_pulse_gen #(
        .DUR_W (DUR_W),
        .DLY_W (DLY_W)
      ) u_gen (
        .clk_in        (CLK_IN),
        .rst_n_in      (RST_N_IN),
        .start_in      (start),
        .level_mode_in (lvl),
        .level_in      (TRIG_WAIT_IN),
        .exp_end_in    (EXP_END_IN),
        .dur_in        (dur_q[g]),
        .dly_in        (pre_on ? {DLY_W{1'b0}} : dly_q[g]),
        .active_out    (act[g])
      );
    end
  endgenerate

  // output lines with inversion; line two drives only in strobe mode
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      // lines low and line two released in reset
      LINE1_OUT      <= 1'b0;
      LINE2_OUT      <= 1'b0;
      LINE2_OE_N_OUT <= 1'b1;
    end else begin
      // line one is always driven, only line two can float
      LINE1_OUT      <= act[0] ^ cfg_q[0][`CFG_INV_BIT];
      LINE2_OUT      <= act[1] ^ cfg_q[1][`CFG_INV_BIT];
      LINE2_OE_N_OUT <= !cfg_q[1][`CFG_MODE_BIT];
    end
  end
endmodule // camera_strobe_output_unit

// ---- design/strobe_out_regs.vh ----
// register map, field positions and timing constants of the strobe output unit
`ifndef STROBE_OUT_REGS_VH
`define STROBE_OUT_REGS_VH

// byte offsets, line one at 0x00, line two at LINE_STRIDE
`define OFS_CFG       8'h00
`define OFS_DUR       8'h04
`define OFS_DLY       8'h08
`define OFS_PRE       8'h0c
`define LINE_STRIDE   8'h10
`define OFS_CMD       8'h20
`define OFS_STATUS    8'h24

// configuration word fields
`define CFG_SRC_LSB   0
`define CFG_SRC_MSB   3
`define CFG_INV_BIT   4
`define CFG_EN_BIT    5
`define CFG_MODE_BIT  6
`define CFG_W         7
`define CFG_RESET     7'h00

// event source codes
`define SRC_EXP_START   4'h0
`define SRC_EXP_END     4'h1
`define SRC_ACQ_START   4'h2
`define SRC_ACQ_STOP    4'h3
`define SRC_BURST_START 4'h4
`define SRC_BURST_END   4'h5
`define SRC_TRIG_WAIT   4'h6
`define SRC_FRAME_START 4'h7
`define SRC_FRAME_END   4'h8
`define SRC_SOFT_TRIG   4'h9
`define SRC_HARD_TRIG   4'ha
`define SRC_CNT_TRIG    4'hb
`define SRC_TIMER       4'hc
`define SRC_COUNT       13

// timing: one microsecond in clock cycles at a 100 ns clock
`define CLK_PERIOD_NS 100
`define ONE_US_NS     1000
`define US_CYCLES     (`ONE_US_NS / `CLK_PERIOD_NS)
`define DLY_MAX_US    10000
`define PRE_MAX_US    5000
`define DUR_W         24
`define DLY_W         14

`endif

// ---- design/strobe_pulse_gen.v ----
// per-line pulse generator: delay, then a timed or exposure-long pulse
`timescale 1ns/1ns
`include "strobe_out_regs.vh"
module strobe_pulse_gen #(
  parameter DUR_W = `DUR_W,                 // duration counter width
  parameter DLY_W = `DLY_W                  // delay counter width
) (
  input  wire             clk_in,           // system clock
  input  wire             rst_n_in,         // synchronous reset, low active
  input  wire             start_in,         // pulse event
  input  wire             level_mode_in,    // follow level_in directly
  input  wire             level_in,         // level source
  input  wire             exp_end_in,       // exposure end pulse
  input  wire [DUR_W-1:0] dur_in,           // duration in us, 0 = exposure
  input  wire [DLY_W-1:0] dly_in,           // delay in us
  output reg              active_out        // source level of the line
);
  localparam ST_IDLE  = 2'd0;               // waiting for an event
  localparam ST_DELAY = 2'd1;               // counting the delay
  localparam ST_PULSE = 2'd2;               // pulse asserted
  localparam integer DIV_LAST_I = `US_CYCLES - 1;  // last cycle of a microsecond
  localparam [3:0] DIV_LAST = DIV_LAST_I[3:0];     // divider end count

  reg [1:0]       state_q;                  // sequencer state
  reg [3:0]       div_q;                    // cycles within the current us
  reg [DUR_W-1:0] cnt_q;                    // remaining microseconds
  wire            wrap = (div_q == DIV_LAST); // a microsecond elapses
  wire            last = wrap && (cnt_q == {{(DUR_W-1){1'b0}}, 1'b1});

  // sequencer; counters reload on each accepted event
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      div_q   <= 4'h0;
      cnt_q   <= {DUR_W{1'b0}};
    end else begin
      div_q <= wrap ? 4'h0 : div_q + 4'h1;
      case (state_q)
        ST_IDLE: begin
          if (start_in && !level_mode_in) begin
            div_q <= 4'h0;
            if (dly_in == {DLY_W{1'b0}}) begin
              state_q <= ST_PULSE;
              cnt_q   <= dur_in;
            end else begin
              state_q <= ST_DELAY;
              cnt_q   <= {{(DUR_W-DLY_W){1'b0}}, dly_in};
            end
          end
        end
        ST_DELAY: begin
          if (wrap)
            cnt_q <= cnt_q - {{(DUR_W-1){1'b0}}, 1'b1};
          if (last) begin
            state_q <= ST_PULSE;
            cnt_q   <= dur_in;
          end
        end
        ST_PULSE: begin
          if (dur_in == {DUR_W{1'b0}}) begin
            if (exp_end_in)
              state_q <= ST_IDLE;
          end else begin
            if (wrap)
              cnt_q <= cnt_q - {{(DUR_W-1){1'b0}}, 1'b1};
            if (last)
              state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // level source passes straight, else the pulse state
  always @(posedge clk_in) begin
    if (!rst_n_in)
      active_out <= 1'b0;
    else if (level_mode_in)
      active_out <= level_in;
    else
      active_out <= (state_q == ST_PULSE);
  end
endmodule // strobe_pulse_gen

// ---- sim/camera_strobe_output_unit_chk.sv ----
// port checker for the strobe output unit
`timescale 1ns/1ns
`include "strobe_out_regs.vh"
module camera_strobe_output_unit_chk #(
  parameter DUR_W = `DUR_W,                 // duration width
  parameter DLY_W = `DLY_W                  // delay width
) (
  input wire        CLK_IN,
  input wire        RST_N_IN,
  input wire        PSEL_IN,
  input wire        PENABLE_IN,
  input wire        PWRITE_IN,
  input wire [7:0]  PADDR_IN,
  input wire [31:0] PWDATA_IN,
  input wire [31:0] PRDATA_OUT,
  input wire        PREADY_OUT,
  input wire        PSLVERR_OUT,
  input wire        EXP_START_OUT,
  input wire        LINE1_OUT,
  input wire        LINE2_OUT,
  input wire        LINE2_OE_N_OUT
);
  // apb phases seen at the pins
  wire setup  = PSEL_IN && !PENABLE_IN;
  wire rd_set = setup && !PWRITE_IN;
  wire wr_acc = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  property p_rdy; setup |=> PREADY_OUT; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_rdy_one; PREADY_OUT |=> !PREADY_OUT; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready held");
  property p_err;
    setup && PADDR_IN > `OFS_STATUS |=> PSLVERR_OUT && (PWRITE_IN || PRDATA_OUT == 0);
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_noerr;
    setup && PADDR_IN[1:0] == 2'h0 && PADDR_IN <= `OFS_STATUS |=> !PSLVERR_OUT;
  endproperty
  a_noerr: assert property (p_noerr) else $error("mapped access refused");
  property p_rsvd; rd_set && PADDR_IN == `OFS_STATUS |=> PRDATA_OUT[31:4] == 0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("status spare bits set");
  property p_cmd_rd; rd_set && PADDR_IN == `OFS_CMD |=> PRDATA_OUT == 0; endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("command reads nonzero");
  property p_oe;
    wr_acc && PADDR_IN == `LINE_STRIDE |-> ##2 LINE2_OE_N_OUT == !$past(PWDATA_IN[6], 2);
  endproperty
  a_oe: assert property (p_oe) else $error("line two enable wrong");
  property p_rst;
    $rose(RST_N_IN) |-> !LINE1_OUT && !LINE2_OUT && LINE2_OE_N_OUT && !EXP_START_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset");
  property p_exp_one; EXP_START_OUT |=> !EXP_START_OUT; endproperty
  a_exp_one: assert property (p_exp_one) else $error("exposure start long");
  cover property (PSLVERR_OUT);
  cover property (EXP_START_OUT);
  cover property (!LINE2_OE_N_OUT);
endmodule // camera_strobe_output_unit_chk

// ---- sim/camera_strobe_output_unit_tb.sv ----
// self-checking bench for the camera strobe output unit
`timescale 1ns/1ns
`include "strobe_out_regs.vh"
module camera_strobe_output_unit_tb;
  logic        clk = 0;              // 10 mhz clock
  logic        rst_n = 0;            // synchronous reset
  logic        psel = 0;             // apb requester
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] ev = 12'h000;         // event pulses by source code
  logic        trig_wait = 0;        // waiting level
  logic        ext_en = 0;           // plc drives line two
  logic        ext_lvl = 0;
  wire  [31:0] prdata;
  wire  [31:0] m_width;              // measured line one width
  wire         pready, pslverr, exp_start, line1, line2, oe_n, pin2;
  int          failures = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          n;
  logic [31:0] r;
  logic        e;
  camera_strobe_output_unit u_dut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EXP_REQ_IN(ev[0]), .EXP_END_IN(ev[1]),
    .ACQ_START_IN(ev[2]), .ACQ_STOP_IN(ev[3]), .BURST_START_IN(ev[4]),
    .BURST_END_IN(ev[5]), .TRIG_WAIT_IN(trig_wait), .FRAME_START_IN(ev[7]),
    .FRAME_END_IN(ev[8]), .SOFT_TRIG_IN(ev[9]), .HARD_TRIG_IN(ev[10]),
    .CNT_TRIG_IN(ev[11]), .EXP_START_OUT(exp_start), .LINE1_OUT(line1),
    .LINE2_OUT(line2), .LINE2_OE_N_OUT(oe_n), .LINE2_IN(pin2));
  strobe_load_model u_load (
    .clk_in(clk), .line1_in(line1), .line2_in(line2), .line2_oe_n_in(oe_n),
    .ext_en_in(ext_en), .ext_lvl_in(ext_lvl), .pin2_out(pin2), .width_out(m_width));
  // clock generator
  initial begin
    forever #50 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, waits for ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk(pready, 1'b1, "ready");
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle cycle keeps the next setup in a later time step
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x, "read data");
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic fire(input int s);
    ev[s] <= 1'b1;
    @(posedge clk);
    ev <= 12'h000;
  endtask
  // line one on a source: delay d us, width 2 us
  task automatic ev_run(input int s, input int d, input int lat);
    wr(`OFS_CFG, 32'h20 | s);
    wr(`OFS_DLY, d);
    wr(`OFS_DUR, 32'h2);
    if (s == 12)
      wr(`OFS_CMD, 32'h1);
    else
      fire(s);
    n = 0;
    while (line1 !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (lat > 0) chk(n, lat + 10 * d, "line one latency");
    tick(24);
    chk(m_width, 32'd20, "line one width");
  endtask
  // main sequence
  initial begin
    tick(10);
    rst_n <= 1'b1;
    tick(2);
    rd(`OFS_CFG, 32'h0);
    rd(`OFS_STATUS, 32'h4);
    rd(`OFS_CMD, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk(e, 1'b1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    apb(1'b1, 8'h28, 32'h0000_00ff);
    chk(e, 1'b1, "unmapped write error");
    wr(`OFS_DLY, 32'd20000);
    rd(`OFS_DLY, 32'd10000);
    wr(`OFS_PRE, 32'd9999);
    rd(`OFS_PRE, 32'd5000);
    wr(`OFS_PRE, 32'h0);
    for (int s = 0; s < 13; s++) begin
      if (s != 6) ev_run(s, s % 3, (s == 0) ? 4 : 3);
    end
    wr(`OFS_CFG, 32'h22);
    wr(`OFS_DLY, 32'h0);
    wr(`OFS_DUR, 32'h0);
    fire(2);
    tick(6);
    fire(1);
    tick(4);
    chk(m_width, 32'd7, "exposure-long width");
    wr(`OFS_CFG, 32'h10);
    tick(3);
    chk(line1, 1'b1, "disabled inverted line");
    wr(`OFS_CFG, 32'h36);
    trig_wait <= 1'b1;
    tick(4);
    chk(line1, 1'b0, "waiting level");
    trig_wait <= 1'b0;
    tick(4);
    chk(line1, 1'b1, "idle level");
    wr(`OFS_CFG, 32'h0);
    wr(`LINE_STRIDE + `OFS_DUR, 32'h1);
    wr(`LINE_STRIDE, 32'h62);
    tick(2);
    chk(oe_n, 1'b0, "line two enable");
    fire(2);
    tick(3);
    chk(pin2, 1'b1, "line two pulse");
    tick(12);
    wr(`LINE_STRIDE, 32'h0);
    ext_en <= 1'b1;
    tick(4);
    chk(oe_n, 1'b1, "line two released");
    rd(`OFS_STATUS, 32'h0);
    wr(`OFS_CFG, 32'h20);
    wr(`OFS_PRE, 32'h3);
    fire(0);
    n = 0;
    while (exp_start !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(n, 32'd31, "hold-off cycles");
    chk(line1, 1'b1, "pulse before exposure");
    fire(1);
    tick(4);
    chk(m_width, 32'd32, "pre-delay width");
    print_verdict();
  end
endmodule // camera_strobe_output_unit_tb
bind camera_strobe_output_unit camera_strobe_output_unit_chk #(.DUR_W(DUR_W), .DLY_W(DLY_W))
  u_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .EXP_START_OUT(EXP_START_OUT),
  .LINE1_OUT(LINE1_OUT), .LINE2_OUT(LINE2_OUT), .LINE2_OE_N_OUT(LINE2_OE_N_OUT));

// ---- sim/strobe_load_model.sv ----
// far-side model: light source or plc input on both lines
`timescale 1ns/1ns
module strobe_load_model (
  input  wire        clk_in,         // system clock
  input  wire        line1_in,       // isolated output line
  input  wire        line2_in,       // line two driven value
  input  wire        line2_oe_n_in,  // low while unit drives
  input  wire        ext_en_in,      // plc drives line two
  input  wire        ext_lvl_in,     // plc level on line two
  output wire        pin2_out,       // resolved line two level
  output reg  [31:0] width_out       // last line one high time
);
  reg [31:0] hi_q = 32'h0;           // cycles high so far
  // wired level, pull-up when nobody drives
  assign pin2_out = !line2_oe_n_in ? line2_in : (ext_en_in ? ext_lvl_in : 1'b1);
  // high time of line one in clock cycles
  always @(posedge clk_in) begin
    if (line1_in === 1'b1) begin
      hi_q <= hi_q + 1;
    end else if (hi_q != 0) begin
      width_out <= hi_q;
      hi_q <= 32'h0;
    end
  end
endmodule // strobe_load_model
